// ### verilog/adc_clock_powerdown_control.sv
// control logic of a 12-bit successive-approximation converter: control
// byte capture, clock mode, acquisition and conversion sequencing,
// power-down and result format, plus an avalon-mm status slave.
// assumes the sar core presents its offset-binary code on sar_code.
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module adc_clock_powerdown_control (
	// clock and control
	input  wire  logic        sys_clk,
	input  wire  logic        rstn,
	input  wire  logic        ce,
	// parallel host port pins
	input  wire  logic        cs_n,
	input  wire  logic        wr_n,
	input  wire  logic        rd_n,
	input  wire  logic [7:0]  data_in,
	output var   logic [11:0] data_out,
	output var   logic        data_oe,
	output var   logic        int_n,
	// conversion clock pin and sar core
	input  wire  logic        ext_clk,
	input  wire  logic [11:0] sar_code,
	output var   logic        conv_busy,
	output var   logic        track,
	output var   logic [2:0]  chan_sel,
	output var   logic        range_sel,
	output var   logic        polarity_sel,
	// power control
	output var   logic        standby_sleep,
	output var   logic        deep_sleep,
	output var   logic        bandgap_en,
	output var   logic        ref_buf_en,
	output var   logic        osc_en,
	// avalon-mm status slave
	input  wire  logic [3:0]  address,
	input  wire  logic        read,
	input  wire  logic        write,
	input  wire  logic [31:0] writedata,
	output var   logic [31:0] readdata,
	output var   logic        waitrequest,
	output var   logic        irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]                    cs_sh;
		logic [2:0]                    wr_sh;
		logic [2:0]                    rd_sh;
		logic [2:0]                    ck_sh;
		logic [7:0]                    d_s1;
		logic [7:0]                    d_s2;
		adc_ctl_pkg::conv_state_e      fsm;
		logic [7:0]                    ctrl;
		logic                          clk_int;
		logic [1:0]                    pd_req;
		logic [1:0]                    pwr;
		logic [3:0]                    cnt;
		logic [4:0]                    div;
		logic [11:0]                   result;
		logic                          doe;
		logic                          int_n;
		logic                          osc_en;
		logic                          ref_buf;
		logic                          bandgap;
		logic [adc_ctl_pkg::NUM_EV-1:0] status;
		logic [adc_ctl_pkg::NUM_EV-1:0] mask;
		logic [31:0]                   rdata;
		logic                          wait_r;
		logic                          irq;
		logic                          busy;
		logic                          trk;
		logic                          stby;
		logic                          deep;
	} ctl_s;

	ctl_s q_reg;
	ctl_s q_next;

	// ----------------------------------------------------------------
	// decoded strobes from the second and third sync stages
	// ----------------------------------------------------------------
	logic        cs_act;
	logic        wr_fall;
	logic        wr_rise;
	logic        rd_fall;
	logic        ck_rise;
	logic        tick;
	logic        done_now;
	logic        wake_now;
	logic [1:0]  pm_in;
	logic [31:0] rd_mux;
	logic [11:0] fmt_code;

	// only stage 1 and 2 are compared; stage 0 feeds stage 1 alone
	assign cs_act  = !q_reg.cs_sh[1];
	assign wr_fall = q_reg.wr_sh[2] && !q_reg.wr_sh[1] && cs_act;
	assign wr_rise = !q_reg.wr_sh[2] && q_reg.wr_sh[1] && cs_act;
	assign rd_fall = q_reg.rd_sh[2] && !q_reg.rd_sh[1] && cs_act;
	// 40 mhz sampling resolves the host clock when kept within spec
	assign ck_rise = !q_reg.ck_sh[2] && q_reg.ck_sh[1];
	// conversion clock: internal divider or sampled pin edges
	assign tick = q_reg.clk_int ? (q_reg.osc_en && q_reg.div == 5'h0)
	                            : ck_rise;
	assign done_now = tick && q_reg.fsm == adc_ctl_pkg::ST_CONV
	                  && q_reg.cnt == adc_ctl_pkg::CONV_CYCLES - 4'h1;
	assign wake_now = wr_fall && q_reg.pwr != adc_ctl_pkg::PWR_AWAKE;
	assign pm_in = {q_reg.d_s2[adc_ctl_pkg::PM_HI_BIT],
	                q_reg.d_s2[adc_ctl_pkg::PM_LO_BIT]};

	// offset-binary from the sar becomes two's complement when bipolar
	assign fmt_code = q_reg.ctrl[adc_ctl_pkg::BIP_BIT]
	                  ? {~sar_code[11], sar_code[10:0]}
	                  : sar_code;

	// avalon read mux
	always_comb begin
		rd_mux = 32'h0;
		case (address)
			adc_ctl_pkg::ADDR_STATUS: rd_mux[2:0] = q_reg.status;
			adc_ctl_pkg::ADDR_MASK:   rd_mux[2:0] = q_reg.mask;
			adc_ctl_pkg::ADDR_CONFIG: rd_mux[12:0] = {q_reg.int_n,
				q_reg.fsm != adc_ctl_pkg::ST_IDLE, q_reg.pwr,
				q_reg.clk_int, q_reg.ctrl};
			default: rd_mux = 32'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [adc_ctl_pkg::NUM_EV-1:0] ev;
		logic [adc_ctl_pkg::NUM_EV-1:0] clr;
		ev = '0;
		clr = '0;
		q_next = q_reg;
		if (!rstn) begin
			// power-on: int_n high, awake, external clock
			q_next = '0;
			q_next.cs_sh = 3'h7;
			q_next.wr_sh = 3'h7;
			q_next.rd_sh = 3'h7;
			q_next.fsm = adc_ctl_pkg::ST_IDLE;
			q_next.int_n = 1'b1;
			q_next.ref_buf = 1'b1;
			q_next.bandgap = 1'b1;
			q_next.wait_r = 1'b1;
		end else if (ce) begin
			// two-flop synchronisers plus an edge stage
			q_next.cs_sh = {q_reg.cs_sh[1:0], cs_n};
			q_next.wr_sh = {q_reg.wr_sh[1:0], wr_n};
			q_next.rd_sh = {q_reg.rd_sh[1:0], rd_n};
			q_next.ck_sh = {q_reg.ck_sh[1:0], ext_clk};
			q_next.d_s1 = data_in;
			q_next.d_s2 = q_reg.d_s1;

			// internal oscillator divider, stopped when not selected
			if (q_reg.osc_en)
				q_next.div = (q_reg.div == 5'h0) ? adc_ctl_pkg::INT_DIV_LAST
				                                 : q_reg.div - 5'h1;
			else
				q_next.div = adc_ctl_pkg::INT_DIV_LAST;

			// acquisition and conversion on the chosen clock
			if (tick) begin
				case (q_reg.fsm)
					adc_ctl_pkg::ST_ACQT: begin
						if (q_reg.cnt == adc_ctl_pkg::ACQ_CYCLES - 4'h1) begin
							q_next.fsm = adc_ctl_pkg::ST_CONV;
							q_next.cnt = 4'h0;
						end else begin
							q_next.cnt = q_reg.cnt + 4'h1;
						end
					end
					adc_ctl_pkg::ST_CONV: begin
						if (done_now) begin
							q_next.fsm = adc_ctl_pkg::ST_IDLE;
							q_next.cnt = 4'h0;
							q_next.result = fmt_code;
							ev[adc_ctl_pkg::EV_DONE] = 1'b1;
							// deferred power-down lands here only
							if (q_reg.pd_req != adc_ctl_pkg::PWR_AWAKE) begin
								q_next.pwr = q_reg.pd_req;
								ev[adc_ctl_pkg::EV_SLEEP] = 1'b1;
							end
						end else begin
							q_next.cnt = q_reg.cnt + 4'h1;
						end
					end
					default: q_next.cnt = q_reg.cnt;
				endcase
			end

			// read strobe releases int_n; a result wins the same cycle
			if (rd_fall)
				q_next.int_n = 1'b1;
			if (done_now)
				q_next.int_n = 1'b0;

			// wake on write falling edge, clock mode untouched
			// a write cycle also drops a pending request; its byte sets a new one
			if (wr_fall) begin
				q_next.pwr = adc_ctl_pkg::PWR_AWAKE;
				q_next.pd_req = adc_ctl_pkg::PWR_AWAKE;
				ev[adc_ctl_pkg::EV_SLEEP] = 1'b0;
				ev[adc_ctl_pkg::EV_WAKE] = wake_now;
			end

			// control byte latched on write rising edge; aborts any run, but ACQ_BIT clear moves a held acquisition to conversion
			if (wr_rise) begin
				q_next.ctrl = q_reg.d_s2;
				q_next.int_n = 1'b1;
				case (pm_in)
					adc_ctl_pkg::PM_EXT: q_next.clk_int = 1'b0;
					adc_ctl_pkg::PM_INT: q_next.clk_int = 1'b1;
					default: q_next.clk_int = q_reg.clk_int;
				endcase
				// standby or full is held until the conversion ends
				q_next.pd_req = pm_in[1] ? pm_in
				                         : adc_ctl_pkg::PWR_AWAKE;
				q_next.cnt = 4'h0;
				// either acquisition style in either clock mode
				if (q_reg.d_s2[adc_ctl_pkg::ACQ_BIT])
					q_next.fsm = adc_ctl_pkg::ST_ACQX;
				else if (q_reg.fsm == adc_ctl_pkg::ST_ACQX)
					q_next.fsm = adc_ctl_pkg::ST_CONV;
				else
					q_next.fsm = adc_ctl_pkg::ST_ACQT;
			end

			// port drives data whatever the power state
			q_next.doe = cs_act && !q_reg.rd_sh[1];
			// power outputs follow the settled state
			q_next.ref_buf = q_next.pwr != adc_ctl_pkg::PM_FULL;
			q_next.bandgap = 1'b1;
			q_next.osc_en = q_next.clk_int
			                && q_next.pwr == adc_ctl_pkg::PWR_AWAKE;
			// state decodes registered so these outputs leave flops directly
			q_next.busy = q_next.fsm == adc_ctl_pkg::ST_CONV;
			q_next.trk  = q_next.fsm == adc_ctl_pkg::ST_ACQT
			              || q_next.fsm == adc_ctl_pkg::ST_ACQX;
			q_next.stby = q_next.pwr == adc_ctl_pkg::PM_STBY;
			q_next.deep = q_next.pwr == adc_ctl_pkg::PM_FULL;

			// avalon slave: one wait cycle, commit when waitrequest low
			if (q_reg.wait_r) begin
				if (read || write) begin
					q_next.wait_r = 1'b0;
					q_next.rdata = rd_mux;
				end
			end else begin
				q_next.wait_r = 1'b1;
				if (write && address == adc_ctl_pkg::ADDR_MASK)
					q_next.mask = writedata[adc_ctl_pkg::NUM_EV-1:0];
				if (read && address == adc_ctl_pkg::ADDR_STATUS)
					clr = q_reg.rdata[adc_ctl_pkg::NUM_EV-1:0];
			end
			// a new event beats the read clear
			q_next.status = (q_reg.status & ~clr) | ev;
			q_next.irq = |(q_next.status & q_next.mask);
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		q_reg <= q_next;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign data_out      = q_reg.result;
	assign data_oe       = q_reg.doe;
	assign int_n         = q_reg.int_n;
	assign conv_busy     = q_reg.busy;
	assign track         = q_reg.trk;
	assign chan_sel      = q_reg.ctrl[adc_ctl_pkg::CHAN_MSB:0];
	assign range_sel     = q_reg.ctrl[adc_ctl_pkg::RNG_BIT];
	assign polarity_sel  = q_reg.ctrl[adc_ctl_pkg::BIP_BIT];
	assign standby_sleep = q_reg.stby;
	assign deep_sleep    = q_reg.deep;
	assign bandgap_en    = q_reg.bandgap;
	assign ref_buf_en    = q_reg.ref_buf;
	assign osc_en        = q_reg.osc_en;
	assign readdata      = q_reg.rdata;
	assign waitrequest   = q_reg.wait_r;
	assign irq           = q_reg.irq;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_clock_kept_pd: assert property (ce && wr_rise && pm_in[1]
		|=> $stable(q_reg.clk_int)) else $error("clock mode changed");
	a_int_clock_sel: assert property (ce && wr_rise && pm_in == adc_ctl_pkg::PM_INT
		|=> q_reg.clk_int) else $error("internal clock not selected");
	a_ext_clock_sel: assert property (ce && wr_rise && pm_in == adc_ctl_pkg::PM_EXT
		|=> !q_reg.clk_int) else $error("external clock not selected");
	a_sleep_at_end: assert property (ce && q_reg.pwr == adc_ctl_pkg::PWR_AWAKE
		&& q_next.pwr != adc_ctl_pkg::PWR_AWAKE |-> done_now)
		else $error("power-down outside conversion end");
	a_wake_on_wr: assert property (ce && wr_fall
		|=> q_reg.pwr == adc_ctl_pkg::PWR_AWAKE ##1 !standby_sleep && !deep_sleep)
		else $error("no wake on write");
	a_deep_buffer_off: assert property (deep_sleep |-> !ref_buf_en && bandgap_en)
		else $error("buffer on in full power-down");
	a_int_low_done: assert property (ce && done_now && !wr_rise
		|=> !int_n) else $error("int_n not low on result");
	a_int_high_read: assert property (ce && rd_fall && !done_now
		|=> int_n) else $error("int_n not released on read");
	a_conv_twelve: assert property (ce && q_reg.fsm == adc_ctl_pkg::ST_CONV
		&& q_next.fsm == adc_ctl_pkg::ST_IDLE
		|-> q_reg.cnt == adc_ctl_pkg::CONV_CYCLES - 4'h1 && tick)
		else $error("conversion length wrong");
	a_code_format: assert property (ce && done_now && !wr_rise
		|=> data_out == $past(fmt_code) && (polarity_sel
		? data_out[11] != $past(sar_code[11]) : data_out[11] == $past(sar_code[11])))
		else $error("result format wrong");
	a_cs_gates_write: assert property (q_reg.cs_sh[1]
		|=> $stable(q_reg.ctrl)) else $error("write taken without select");
	a_read_in_sleep: assert property (ce && q_reg.cs_sh[1:0] == 2'h0
		&& q_reg.rd_sh[1] == 1'b0 |=> data_oe)
		else $error("port idle while selected");

	c_conv_done: cover property (done_now);
	c_deep_sleep: cover property ($rose(deep_sleep));
	c_wake: cover property (ce && wake_now);
	c_ext_acq: cover property (q_reg.fsm == adc_ctl_pkg::ST_ACQX
		##1 q_reg.fsm == adc_ctl_pkg::ST_CONV);
endmodule : adc_clock_powerdown_control
`default_nettype wire

// ### verilog/adc_ctl_pkg.sv
// constants shared by the converter control block: control byte layout,
// power and clock codes, sequencing counts and the status register map.
// assumes nothing beyond a SystemVerilog elaborator.
package adc_ctl_pkg;
	// ----------------------------------------------------------------
	// control byte fields
	// ----------------------------------------------------------------
	localparam int PM_HI_BIT = 7;
	localparam int PM_LO_BIT = 6;
	localparam int ACQ_BIT   = 5;
	localparam int RNG_BIT   = 4;
	localparam int BIP_BIT   = 3;
	localparam int CHAN_MSB  = 2;

	// power-mode codes; awake shares the external clock code
	localparam logic [1:0] PM_EXT   = 2'h0;
	localparam logic [1:0] PM_INT   = 2'h1;
	localparam logic [1:0] PM_STBY  = 2'h2;
	localparam logic [1:0] PM_FULL  = 2'h3;
	localparam logic [1:0] PWR_AWAKE = 2'h0;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	localparam logic [3:0] ACQ_CYCLES  = 4'h6;
	localparam logic [3:0] CONV_CYCLES = 4'hc;
	localparam int SYS_CLK_KHZ  = 40000;
	localparam int INT_OSC_KHZ  = 1560;
	localparam int INT_DIV      = SYS_CLK_KHZ / INT_OSC_KHZ;
	localparam logic [4:0] INT_DIV_LAST = 5'(INT_DIV - 1);

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ACQT = 4'b0010,
		ST_ACQX = 4'b0100,
		ST_CONV = 4'b1000
	} conv_state_e;

	// ----------------------------------------------------------------
	// status register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_MASK   = 4'h4;
	localparam logic [3:0] ADDR_CONFIG = 4'h8;
	localparam int EV_DONE  = 0;
	localparam int EV_SLEEP = 1;
	localparam int EV_WAKE  = 2;
	localparam int NUM_EV   = 3;
endpackage : adc_ctl_pkg

// ### tb/host_port_model.sv
// processor model for the parallel port: strobes, control byte, conversion clock.
// assumes a 40 mhz sys_clk; the bench sequences the tasks after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
	// clock
	input  wire logic       sys_clk,
	// parallel port pins
	output var  logic       cs_n,
	output var  logic       wr_n,
	output var  logic       rd_n,
	output var  logic [7:0] data_in,
	output var  logic       ext_clk
);
	logic [4:0] div_reg = 5'h00;

	// idle bus at time zero
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		data_in = 8'h00;
		ext_clk = 1'b0;
	end

	// free conversion clock: 2 mhz, even duty
	always @(posedge sys_clk) begin
		div_reg <= (div_reg == 5'h13) ? 5'h00 : div_reg + 5'h01;
		ext_clk <= (div_reg < 5'h0a);
	end

	// select, set the byte up early, then drop the strobe
	task automatic wr_begin(input logic [7:0] b, input logic sel);
		@(posedge sys_clk);
		cs_n <= ~sel;
		data_in <= b;
		repeat (4) @(posedge sys_clk);
		wr_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : wr_begin

	// raise the strobe with the byte still stable, then let the bus go
	task automatic wr_end(input logic [7:0] b);
		@(posedge sys_clk);
		wr_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		cs_n <= 1'b1;
		data_in <= ~b;
	endtask : wr_end

	// read cycle opened and held
	task automatic rd_begin();
		@(posedge sys_clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask : rd_begin

	// read cycle closed
	task automatic rd_end();
		@(posedge sys_clk);
		rd_n <= 1'b1;
		cs_n <= 1'b1;
	endtask : rd_end
endmodule : host_port_model
`default_nettype wire

// ### tb/adc_clock_powerdown_control_tb_top.sv
// self-checking bench: parallel port through the host model, status over avalon.
// assumes the package constants and a 40 mhz clock.
`timescale 1ns/1ps
`default_nettype none
module adc_clock_powerdown_control_tb_top;
	logic        sys_clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, ce = 1'b1;
	logic        cs_n, wr_n, rd_n, ext_clk, data_oe, int_n, conv_busy, track;
	logic        range_sel, polarity_sel, standby_sleep, deep_sleep;
	logic        bandgap_en, ref_buf_en, osc_en, waitrequest, irq;
	logic [2:0]  chan_sel;
	logic [3:0]  address = 4'h0;
	logic [7:0]  data_in;
	logic [11:0] data_out, sar_code = 12'h9a5;
	logic [31:0] writedata = 32'h0, readdata, rv;
	int          err_total = 0, checked = 0, n, busy_len;

	// clock
	always #12.5 sys_clk = ~sys_clk;

	adc_clock_powerdown_control dut_u (.sys_clk, .rstn, .ce, .cs_n, .wr_n,
		.rd_n, .data_in, .data_out, .data_oe, .int_n, .ext_clk, .sar_code,
		.conv_busy, .track, .chan_sel, .range_sel, .polarity_sel, .standby_sleep,
		.deep_sleep, .bandgap_en, .ref_buf_en, .osc_en, .address, .read, .write,
		.writedata, .readdata, .waitrequest, .irq);

	host_port_model host_u (.sys_clk, .cs_n, .wr_n, .rd_n, .data_in, .ext_clk);

	// conversion length meter
	always @(posedge sys_clk) if (conv_busy === 1'b1) busy_len <= busy_len + 1;

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic print_verdict();
		if (err_total == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	// avalon transfer, held until waitrequest is sampled low
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		read <= ~wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do begin
			@(posedge sys_clk);
		end while (waitrequest !== 1'b0);
		rv = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(negedge sys_clk);
	endtask : av

	task automatic wb(input logic [7:0] b);
		host_u.wr_begin(b, 1'b1);
		host_u.wr_end(b);
		@(negedge sys_clk);
	endtask : wb

	// bounded wait for the interrupt pin level
	task automatic wait_int(input logic lvl);
		n = 0;
		while (int_n !== lvl && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		chk("int_n", int_n, lvl);
	endtask : wait_int

	// write a power-down byte: wakes at the strobe, sleeps after conversion
	task automatic sleep_cycle(input logic [7:0] b, input logic [4:0] pw,
		input logic [2:0] cfg);
		host_u.wr_begin(b, 1'b1);
		@(negedge sys_clk);
		chk("asleep", {standby_sleep, deep_sleep}, 2'h0);
		host_u.wr_end(b);
		@(negedge sys_clk);
		chk("busy", track | conv_busy, 1'b1);
		wait_int(1'b0);
		repeat (3) @(negedge sys_clk);
		chk("power", {standby_sleep, deep_sleep, ref_buf_en, bandgap_en, osc_en}, pw);
		av(1'b0, 4'h8, 32'h0);
		chk("config", rv[10:8], cfg);
	endtask : sleep_cycle

	// watchdog
	initial begin
		repeat (40000) @(posedge sys_clk);
		err_total++;
		print_verdict();
	end

	// test sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		chk("int_n", int_n, 1'b1);
		chk("power", {standby_sleep, deep_sleep, ref_buf_en, bandgap_en, osc_en}, 5'h06);
		av(1'b0, 4'hc, 32'h0);
		chk("unmapped", rv, 32'h0);
		av(1'b1, 4'h4, 32'h0);
		busy_len = 0;
		wb(8'h45);
		chk("osc_en", osc_en, 1'b1);
		wait_int(1'b0);
		chk("conv_len", 32'(busy_len >= 250 && busy_len <= 325), 32'h1);
		chk("data_out", data_out, 12'h9a5);
		chk("fields", {polarity_sel, range_sel, chan_sel}, 5'h05);
		chk("irq", irq, 1'b0);
		av(1'b1, 4'h4, 32'h7);
		chk("irq", irq, 1'b1);
		av(1'b0, 4'h0, 32'h0);
		chk("status", rv[2:0], 3'h1);
		av(1'b0, 4'h0, 32'h0);
		chk("status", rv[2:0], 3'h0);
		chk("irq", irq, 1'b0);
		host_u.rd_begin();
		@(negedge sys_clk);
		chk("data_oe", data_oe, 1'b1);
		chk("int_n", int_n, 1'b1);
		host_u.rd_end();
		// held acquisition in internal clock mode, then conversion
		wb(8'h60);
		repeat (400) @(negedge sys_clk);
		chk("acq", {track, conv_busy, int_n}, 3'h5);
		wb(8'h40);
		wait_int(1'b0);
		host_u.wr_begin(8'h0b, 1'b0);
		host_u.wr_end(8'h0b);
		av(1'b0, 4'h8, 32'h0);
		chk("config", rv[7:0], 8'h40);
		chk("int_n", int_n, 1'b0);
		// bipolar, external clock
		wb(8'h0a);
		chk("int_n", int_n, 1'b1);
		chk("osc_en", osc_en, 1'b0);
		wait_int(1'b0);
		chk("data_out", data_out, 12'h1a5);
		sleep_cycle(8'h88, 5'h16, 3'h4);
		host_u.rd_begin();
		@(negedge sys_clk);
		chk("data_oe", data_oe, 1'b1);
		chk("data_out", data_out, 12'h1a5);
		host_u.rd_end();
		sleep_cycle(8'h88, 5'h16, 3'h4);
		wb(8'h40);
		wait_int(1'b0);
		sleep_cycle(8'hc0, 5'h0a, 3'h7);
		// wake from full power-down: internal clock back before the byte lands
		host_u.wr_begin(8'h95, 1'b1);
		@(negedge sys_clk);
		chk("osc_en", osc_en, 1'b1);
		host_u.wr_end(8'h95);
		// clock enable low freezes the running acquisition
		@(posedge sys_clk);
		ce <= 1'b0;
		repeat (1000) @(negedge sys_clk);
		chk("frozen", {track | conv_busy, int_n}, 2'h3);
		@(posedge sys_clk);
		ce <= 1'b1;
		wait_int(1'b0);
		chk("fields", {polarity_sel, range_sel, chan_sel}, 5'h0d);
		av(1'b0, 4'h0, 32'h0);
		chk("status", rv[2:0], 3'h7);
		chk("irq", irq, 1'b0);
		print_verdict();
	end
endmodule : adc_clock_powerdown_control_tb_top
`default_nettype wire
